// ==== rtl/path_cfg_defines.svh ====
// Offsets, field positions and reset values of the forward-loaded register bank
`ifndef PATH_CFG_DEFINES_SVH
`define PATH_CFG_DEFINES_SVH
`define ADDR_PATH_CFG 8'h28
`define ADDR_AUDIO_CTL 8'h2B
`define ADDR_PCLK_TEST 8'h2E
`define ADDR_RX_PORT_SEL 8'h34
`define BIT_OVERRIDE 7
`define BIT_RSVD6 6
`define BIT_VIDEO_OFF 5
`define BIT_DUAL_LINK 4
`define BIT_ALT_AUDIO 3
`define BIT_AUDIO_OFF 2
`define BIT_SYNC_PAYLOAD 1
`define BIT_SURROUND 0
`define BIT_OVERRUN 3
`define BIT_UNDERRUN 2
`define BIT_ERR_CLR 1
`define BIT_EDGE 0
`define BIT_EXT_PCLK 7
`define RST_PATH_CFG 8'h00
`define RST_AUDIO_CTL 8'h00
`define RST_PCLK_TEST 8'h00
// Bits of the path register that the forward channel may load
`define FWD_LOAD_MASK 8'h3F
`endif

// ==== rtl/path_cfg_pkg.sv ====
// Types shared by the forward-loaded register bank
package path_cfg_pkg;
    typedef logic [7:0] reg_byte_type;
    typedef enum logic [1:0] {
        LANE_AUTO = 2'b00,
        LANE_DUAL = 2'b01,
        LANE_SINGLE_PRI = 2'b10,
        LANE_SINGLE_SEC = 2'b11
    } lane_mode_type;
endpackage

// ==== rtl/sticky_flag.sv ====
// Sticky event flag where a set wins over a clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_reg;
    logic flag_next;
    assign flag_next = set_i | (flag_reg & ~clr_i);
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end
    assign flag_o = flag_reg;
    chk_flag_holds: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) flag_reg && !clr_i |=> flag_reg)
        else $error("sticky flag dropped without clear");
    // An event that meets a clear must not be lost
    chk_set_wins: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) set_i && clr_i |=> flag_reg)
        else $error("set lost against clear");
endmodule
`default_nettype wire

// ==== rtl/path_cfg_bank.sv ====
// Forward-loaded datapath, audio serial and pixel clock test registers
`timescale 1ns/1ps
`default_nettype none
`include "path_cfg_defines.svh"
module path_cfg_bank
    import path_cfg_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic fwd_load_i,
    input wire logic [7:0] fwd_cfg_i,
    input wire logic [1:0] lane_mode_i,
    input wire logic fifo_overrun_i,
    input wire logic fifo_underrun_i,
    input wire logic recovered_pclk_i,
    input wire logic test_clock_pin_i,
    output logic video_off_o,
    output logic ctl_channel_en_o,
    output logic gpio_fwd_en_o,
    output logic dual_recover_o,
    output logic alt_audio_gpio_o,
    output logic audio_off_o,
    output logic sync_in_payload_en_o,
    output logic surround_en_o,
    output logic audio_rise_edge_o,
    output logic pixel_clk_o
);
    // Offsets are 8 bits wide, so a narrower address could not reach them
    if (ADDR_W < 8) begin : g_addr_w_check
        $error("ADDR_W must be at least 8");
    end

    reg_byte_type path_reg, path_next;
    reg_byte_type audio_reg, audio_next;
    reg_byte_type test_reg, test_next;
    logic overrun_flag, underrun_flag;
    reg_byte_type rdata_next;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction

    wire wr_path = reg_wr_i & hit(reg_addr_i, `ADDR_PATH_CFG);
    wire wr_audio = reg_wr_i & hit(reg_addr_i, `ADDR_AUDIO_CTL);
    wire wr_test = reg_wr_i & hit(reg_addr_i, `ADDR_PCLK_TEST);
    wire override = path_reg[`BIT_OVERRIDE];
    wire fifo_err_clr = wr_audio & reg_wdata_i[`BIT_ERR_CLR];
    wire [7:0] fwd_mask = `FWD_LOAD_MASK;
    wire [7:0] dual_mask = 8'h01 << `BIT_DUAL_LINK;
    // Local write keeps dual-link bit; forward load touches only loadable bits
    wire [7:0] local_val = (reg_wdata_i & ~dual_mask) | (path_reg & dual_mask);
    wire [7:0] fwd_val = (fwd_cfg_i & fwd_mask) | (path_reg & ~fwd_mask);
    // Under override only the dual-link bit still follows the forward channel
    wire [7:0] fwd_dual = (fwd_cfg_i & dual_mask) | (path_reg & ~dual_mask);

    // A same-cycle local write wins for writable bits; dual link always loads
    always_comb begin
        path_next = path_reg;
        if (wr_path) begin
            path_next = local_val;
        end else if (fwd_load_i && !override) begin
            path_next = fwd_val;
        end else if (fwd_load_i) begin
            path_next = fwd_dual;
        end
        if (fwd_load_i) begin
            path_next[`BIT_DUAL_LINK] = fwd_cfg_i[`BIT_DUAL_LINK];
        end
    end

    always_comb begin
        audio_next = audio_reg;
        if (wr_audio) begin
            audio_next = reg_wdata_i;
            audio_next[`BIT_OVERRUN] = 1'b0;
            audio_next[`BIT_UNDERRUN] = 1'b0;
        end
    end
    assign test_next = wr_test ? reg_wdata_i : test_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            path_reg <= `RST_PATH_CFG;
            audio_reg <= `RST_AUDIO_CTL;
            test_reg <= `RST_PCLK_TEST;
        end else begin
            path_reg <= path_next;
            audio_reg <= audio_next;
            test_reg <= test_next;
        end
    end

    // Errors latch until software clears them
    sticky_flag u_overrun (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .set_i(fifo_overrun_i),
        .clr_i(fifo_err_clr),
        .flag_o(overrun_flag)
    );
    sticky_flag u_underrun (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .set_i(fifo_underrun_i),
        .clr_i(fifo_err_clr),
        .flag_o(underrun_flag)
    );

    wire [7:0] audio_rd = {audio_reg[7:4], overrun_flag, underrun_flag,
                           audio_reg[1:0]};
    wire rd_path = hit(reg_addr_i, `ADDR_PATH_CFG);
    wire rd_audio = hit(reg_addr_i, `ADDR_AUDIO_CTL);
    wire rd_test = hit(reg_addr_i, `ADDR_PCLK_TEST);
    assign rdata_next = rd_path ? path_reg :
                        rd_audio ? audio_rd :
                        rd_test ? test_reg : 8'h00;
    // Read data is combinational from flops so a read sees state this cycle
    assign reg_rdata_o = rdata_next;

    assign video_off_o = path_reg[`BIT_VIDEO_OFF];
    // Control and GPIO forwarding never depend on the video-off flag
    assign ctl_channel_en_o = 1'b1;
    assign gpio_fwd_en_o = 1'b1;
    // Forced modes come from the 0x34 lane selection outside this bank
    assign dual_recover_o = (lane_mode_i == LANE_AUTO) ?
                            path_reg[`BIT_DUAL_LINK] :
                            (lane_mode_i == LANE_DUAL);
    assign alt_audio_gpio_o = path_reg[`BIT_ALT_AUDIO];
    assign audio_off_o = path_reg[`BIT_AUDIO_OFF];
    assign sync_in_payload_en_o = path_reg[`BIT_SYNC_PAYLOAD];
    assign surround_en_o = path_reg[`BIT_SURROUND];
    assign audio_rise_edge_o = audio_reg[`BIT_EDGE];
    // Plain mux: a glitch-free clock switch is left to the clock tree
    assign pixel_clk_o = test_reg[`BIT_EXT_PCLK] ? test_clock_pin_i :
                         recovered_pclk_i;

    sequence s_fwd_open;
        fwd_load_i && !override && !wr_path;
    endsequence
    sequence s_fwd_frozen;
        override && fwd_load_i && !wr_path;
    endsequence
    sequence s_overrun_kept;
        fifo_overrun_i ##1 !fifo_err_clr [*2];
    endsequence
    sequence s_ext_pclk_set;
        wr_test ##1 test_reg[`BIT_EXT_PCLK];
    endsequence

    chk_fwd_load: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) s_fwd_open |=>
        path_reg[5:0] == $past(fwd_cfg_i[5:0]))
        else $error("forward load missed");
    // Override and reserved storage belong to software alone
    chk_fwd_keep_top: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) fwd_load_i && !wr_path |=>
        path_reg[7:6] == $past(path_reg[7:6]))
        else $error("forward load touched local bits");
    chk_override_hold: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) s_fwd_frozen |=>
        path_reg[3:0] == $past(path_reg[3:0]))
        else $error("override did not freeze");
    chk_local_write: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) wr_path |=>
        {path_reg[7:5], path_reg[3:0]} ==
        $past({reg_wdata_i[7:5], reg_wdata_i[3:0]}))
        else $error("local write lost");
    chk_video_load: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) s_fwd_open |=>
        video_off_o == $past(fwd_cfg_i[`BIT_VIDEO_OFF]))
        else $error("video flag not reported");
    chk_ctl_alive: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) video_off_o |->
        ctl_channel_en_o && gpio_fwd_en_o)
        else $error("forwarding stopped without video");
    chk_video_freeze: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) s_fwd_frozen |=>
        $stable(video_off_o))
        else $error("video flag changed under override");
    chk_dual_ro: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) wr_path && !fwd_load_i |=>
        $stable(path_reg[`BIT_DUAL_LINK]))
        else $error("dual link bit written locally");
    chk_dual_load: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) fwd_load_i |=>
        path_reg[`BIT_DUAL_LINK] == $past(fwd_cfg_i[`BIT_DUAL_LINK]))
        else $error("dual link bit not loaded");
    chk_auto_lane: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) lane_mode_i == LANE_AUTO |->
        dual_recover_o == path_reg[`BIT_DUAL_LINK])
        else $error("auto lane mode ignores dual flag");
    // A write without the clear bit must leave both status bits alone
    chk_overrun_ro: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) wr_audio && !fifo_err_clr && !fifo_overrun_i
        |=> $stable(audio_rd[`BIT_OVERRUN]))
        else $error("overrun status written");
    chk_underrun_ro: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) wr_audio && !fifo_err_clr && !fifo_underrun_i
        |=> $stable(audio_rd[`BIT_UNDERRUN]))
        else $error("underrun status written");
    chk_err_clear: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i)
        fifo_err_clr && !fifo_overrun_i && !fifo_underrun_i |=>
        audio_rd[3:2] == 2'b00)
        else $error("error clear failed");
    chk_edge_sel: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) wr_audio |=>
        audio_rise_edge_o == $past(reg_wdata_i[`BIT_EDGE]))
        else $error("strobe edge not taken");
    chk_pclk_sel: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) s_ext_pclk_set |->
        pixel_clk_o == test_clock_pin_i)
        else $error("pixel clock not from test pin");
    chk_pclk_recov: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) !test_reg[`BIT_EXT_PCLK] |->
        pixel_clk_o == recovered_pclk_i)
        else $error("pixel clock not from recovered clock");
    chk_err_sticky: assert property (@(posedge core_clk_i)
        disable iff (!nrst_i) s_overrun_kept |=> audio_rd[`BIT_OVERRUN])
        else $error("overrun status lost");
endmodule
`default_nettype wire

// ==== test/remote_serializer_model.sv ====
// Remote serializer model driving forward-channel settings
`timescale 1ns/1ps
`default_nettype none
module remote_serializer_model (
    input wire logic core_clk_i,
    output logic fwd_load_o,
    output logic [7:0] fwd_cfg_o
);
    initial begin
        fwd_load_o = 1'b0;
        fwd_cfg_o = 8'h00;
    end
    // Idle bus shows the inverse so a stale value never looks valid
    task automatic send(input logic [7:0] cfg);
        @(negedge core_clk_i);
        fwd_load_o = 1'b1;
        fwd_cfg_o = cfg;
        @(negedge core_clk_i);
        fwd_load_o = 1'b0;
        fwd_cfg_o = ~cfg;
    endtask
endmodule
`default_nettype wire

// ==== test/path_cfg_bank_tb.sv ====
// Self-checking bench of the forward-loaded register bank
`timescale 1ns/1ps
`default_nettype none
module path_cfg_bank_tb;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cfg, d, pexp, fcfg;
    logic wr = 1'b0, ovr = 1'b0, und = 1'b0, rpclk = 1'b0, tpin = 1'b0;
    logic [1:0] lane = 2'b00;
    logic fload, voff, cen, gen, dual, alt, aoff, syncp, surr, rise, pclk;
    int miscompares = 0;
    int samples_checked = 0;
    logic [7:0] outs;
    logic lexp;
    assign outs = {2'b00, voff, 1'b0, alt, aoff, syncp, surr};
    always #4 core_clk_i = ~core_clk_i;
    remote_serializer_model fwd (.core_clk_i(core_clk_i),
        .fwd_load_o(fload), .fwd_cfg_o(fcfg));
    path_cfg_bank #(.ADDR_W(8)) dut (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .fwd_load_i(fload),
        .fwd_cfg_i(fcfg), .lane_mode_i(lane), .fifo_overrun_i(ovr),
        .fifo_underrun_i(und), .recovered_pclk_i(rpclk),
        .test_clock_pin_i(tpin), .video_off_o(voff),
        .ctl_channel_en_o(cen), .gpio_fwd_en_o(gen),
        .dual_recover_o(dual), .alt_audio_gpio_o(alt),
        .audio_off_o(aoff), .sync_in_payload_en_o(syncp),
        .surround_en_o(surr), .audio_rise_edge_o(rise),
        .pixel_clk_o(pclk));
    // Local write keeps the forward-owned dual-link bit
    function automatic logic [7:0] after_wr(logic [7:0] o, logic [7:0] w);
        return (w & 8'hEF) | (o & 8'h10);
    endfunction
    function automatic logic [7:0] after_fwd(logic [7:0] o, logic [7:0] c);
        if (o[7])
            return (o & 8'hEF) | (c & 8'h10);
        return (o & 8'hC0) | (c & 8'h3F);
    endfunction
    task automatic check(input logic [7:0] seen, exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, w);
        @(negedge core_clk_i);
        addr = a;
        wdata = w;
        wr = 1'b1;
        @(negedge core_clk_i);
        wr = 1'b0;
    endtask
    // Address moves only on a falling edge, data is looked at 1 ns later
    task automatic rd_chk(input logic [7:0] a, exp, input string msg);
        @(negedge core_clk_i);
        addr = a;
        #1;
        check(rdata, exp, msg);
    endtask
    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check_path();
        rd_chk(8'h28, pexp, "path register");
        check(outs, pexp & 8'h2F, "path outputs");
        check({7'h00, syncp}, {7'h00, pexp[1]}, "sync payload");
        check({7'h00, surr}, {7'h00, pexp[0]}, "surround");
        check({6'h00, cen, gen}, 8'h03, "forwarding on");
        // Forced modes first so that auto mode stays selected afterwards
        for (int m = 3; m >= 0; m--) begin
            @(negedge core_clk_i);
            lane = 2'(m);
            lexp = (m == 0) ? pexp[4] : (m == 1);
            #1;
            check({7'h00, dual}, {7'h00, lexp}, "lane recovery");
        end
    endtask
    initial begin
        void'($urandom(51));
        repeat (8) @(posedge core_clk_i);
        @(negedge core_clk_i);
        nrst_i = 1'b1;
        pexp = 8'h00;
        check_path();
        rd_chk(8'h2B, 8'h00, "audio reset");
        rd_chk(8'h2E, 8'h00, "test reset");
        rd_chk(8'h34, 8'h00, "lane select lies outside");
        for (int i = 0; i < 10; i++) begin
            cfg = (i == 0) ? 8'hFF : 8'($urandom);
            fwd.send(cfg);
            pexp = after_fwd(pexp, cfg);
            check_path();
            d = 8'($urandom) | 8'h80;
            wr_reg(8'h28, d);
            pexp = after_wr(pexp, d);
            check_path();
            fwd.send(~pexp);
            pexp = after_fwd(pexp, ~pexp);
            check_path();
            wr_reg(8'h28, 8'h00);
            pexp = after_wr(pexp, 8'h00);
        end
        @(negedge core_clk_i);
        ovr = 1'b1;
        @(negedge core_clk_i);
        ovr = 1'b0;
        rd_chk(8'h2B, 8'h08, "overrun seen");
        repeat (3) @(negedge core_clk_i);
        rd_chk(8'h2B, 8'h08, "overrun held");
        @(negedge core_clk_i);
        und = 1'b1;
        @(negedge core_clk_i);
        und = 1'b0;
        rd_chk(8'h2B, 8'h0C, "underrun seen");
        wr_reg(8'h2B, 8'h00);
        rd_chk(8'h2B, 8'h0C, "status kept");
        // Clear and a fresh overrun in one cycle: the event must survive
        @(negedge core_clk_i);
        addr = 8'h2B;
        wdata = 8'h02;
        wr = 1'b1;
        ovr = 1'b1;
        @(negedge core_clk_i);
        wr = 1'b0;
        ovr = 1'b0;
        rd_chk(8'h2B, 8'h0A, "set wins over clear");
        wr_reg(8'h2B, 8'hF3);
        rd_chk(8'h2B, 8'hF3, "errors cleared");
        check({7'h00, rise}, 8'h01, "rising strobe");
        wr_reg(8'h2B, 8'h0C);
        rd_chk(8'h2B, 8'h00, "status not writable");
        check({7'h00, rise}, 8'h00, "falling strobe");
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            wr_reg(8'h2E, d);
            rpclk = 1'($urandom);
            tpin = ~rpclk;
            lexp = d[7] ? tpin : rpclk;
            rd_chk(8'h2E, d, "test register");
            check({7'h00, pclk}, {7'h00, lexp}, "pixel clock");
        end
        // Reset again mid-run: loaded and written values must all drop
        fwd.send(8'h2F);
        @(negedge core_clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        nrst_i = 1'b1;
        pexp = 8'h00;
        check_path();
        rd_chk(8'h2E, 8'h00, "test reset again");
        check({7'h00, pclk}, {7'h00, rpclk}, "recovered clock");
        final_report();
    end
endmodule
`default_nettype wire
